// ===== swm_pkg.sv
package swm_pkg;
    localparam int CLK_MHZ = 40;
    // Times in microseconds, then the same times in clock cycles.
    localparam int RESET_LOW_US = 480;
    localparam int RESET_LOW_MAX_US = 960;
    localparam int RESET_HIGH_US = 480;
    localparam int PRESENCE_WAIT_MAX_US = 60;
    localparam int PRESENCE_SAMPLE_US = 70;
    localparam int SLOT_US = 70;
    localparam int ONE_LOW_US = 6;
    localparam int ZERO_LOW_US = 64;
    localparam int READ_LOW_US = 2;
    localparam int READ_SAMPLE_US = 12;
    localparam int RECOVERY_US = 3;
    localparam int RESET_LOW_CYC = RESET_LOW_US * CLK_MHZ;
    localparam int RESET_HIGH_CYC = RESET_HIGH_US * CLK_MHZ;
    localparam int PRESENCE_SAMPLE_CYC = PRESENCE_SAMPLE_US * CLK_MHZ;
    localparam int SLOT_CYC = SLOT_US * CLK_MHZ;
    localparam int ONE_LOW_CYC = ONE_LOW_US * CLK_MHZ;
    localparam int ZERO_LOW_CYC = ZERO_LOW_US * CLK_MHZ;
    localparam int READ_LOW_CYC = READ_LOW_US * CLK_MHZ;
    localparam int READ_SAMPLE_CYC = READ_SAMPLE_US * CLK_MHZ;
    localparam int RECOVERY_CYC = RECOVERY_US * CLK_MHZ;
    localparam int CNT_W = 16;
    localparam logic [7:0] CRC_POLY_REV = 8'h8c;
    localparam logic [7:0] CRC_INIT = 8'h00;
    localparam logic [7:0] READ_ROM_CMD = 8'h33;
    localparam int ROM_BITS = 64;
    localparam int DATA_BITS = 56;
    typedef enum logic [2:0] {
        SWM_IDLE = 3'b000,
        SWM_RST_LOW = 3'b001,
        SWM_RST_HIGH = 3'b010,
        SWM_SLOT_LOW = 3'b011,
        SWM_SLOT_REST = 3'b100,
        SWM_RECOVER = 3'b101
    } swm_state_t;
    typedef enum logic [1:0] {
        SWM_OP_RESET = 2'b00,
        SWM_OP_WRITE = 2'b01,
        SWM_OP_READ = 2'b10,
        SWM_OP_ROM = 2'b11
    } swm_op_t;
endpackage : swm_pkg

// ===== swm_crc_if.sv
`timescale 1ns/1ps
interface swm_crc_if;
    logic clear;
    logic shift;
    logic bit_in;
    logic [7:0] value;
    modport ctl (output clear, output shift, output bit_in, input value);
    modport crc (input clear, input shift, input bit_in, output value);
endinterface : swm_crc_if

// ===== swm_crc.sv
`timescale 1ns/1ps
module swm_crc (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // Control and result
    swm_crc_if.crc crc
);
    import swm_pkg::*;
    logic [7:0] crc_q;
    logic [7:0] crc_d;

    // One bit of the reflected x8+x5+x4+1 divider, fed in arrival order.
    function automatic logic [7:0] crc_step(logic [7:0] c, logic b);
        logic fb;
        fb = c[0] ^ b;
        crc_step = (c >> 1) ^ (fb ? CRC_POLY_REV : 8'h00);
    endfunction : crc_step

    always_comb begin
        crc_d = crc_q;
        if (crc.clear) begin
            crc_d = CRC_INIT;
        end else if (crc.shift) begin
            crc_d = crc_step(crc_q, crc.bit_in);
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            crc_q <= CRC_INIT;
        end else begin
            crc_q <= crc_d;
        end
    end

    assign crc.value = crc_q;
endmodule : swm_crc

// ===== swm_master.sv
`timescale 1ns/1ps
// Behaviour
// - A write-one slot lasts 60 to under 120 us with a low of 1 to under 15 us and at least 1 us recovery.
// - To read, the master pulls low, releases and samples before 15 us from the fall.
// - After a reset the master waits a high interval of at least 480 us before anything else.
// - The reset low pulse stays at no more than 960 us.
// - The check value covers family code and serial number only, bit by bit.
// - The computed check is compared with the last eight ROM bits; mismatch flags an error.
// - The check accumulator is cleared to zero before a ROM read.
// - The check uses x8+x5+x4+1 in a right-shifting register, bits in arrival order.
// - Every byte is sent and received least significant bit first.
// - Each transaction starts with a reset low of at least 480 us, then release and listen; only reset and ROM commands do, not write or read.
module swm_master (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // Command port
    input wire logic i_cmd_valid,
    input wire swm_pkg::swm_op_t i_cmd_op,
    input wire logic [7:0] i_cmd_data,
    output logic o_cmd_ready,
    // Result port
    output logic o_done,
    output logic [7:0] o_rd_data,
    output logic [63:0] o_rom,
    output logic o_presence,
    output logic o_crc_err,
    // Line pins
    input wire logic i_line,
    output logic o_line,
    output logic o_line_oe
);
    import swm_pkg::*;

    swm_crc_if crc_bus ();
    swm_crc u_crc (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .crc(crc_bus.crc)
    );

    logic line_meta_q;
    logic line_sync_q;
    swm_state_t state_q, state_d;
    swm_op_t op_q, op_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [6:0] bit_q, bit_d;
    logic [6:0] nbits_q, nbits_d;
    logic [63:0] sh_q, sh_d;
    logic bitval_q, bitval_d;
    logic done_q, done_d;
    logic [7:0] rd_q, rd_d;
    logic [63:0] rom_q, rom_d;
    logic pres_q, pres_d;
    logic err_q, err_d;
    logic seen_q, seen_d;

    function automatic logic [CNT_W-1:0] cyc(int n);
        cyc = CNT_W'(n - 1);
    endfunction : cyc

    // Two-stage synchroniser on the shared line.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            line_meta_q <= 1'b1;
            line_sync_q <= 1'b1;
        end else begin
            line_meta_q <= i_line;
            line_sync_q <= line_meta_q;
        end
    end

    // Reading means the slot carries the master's one and the slave answers.
    logic reading;
    assign reading = (op_q != SWM_OP_WRITE) && !(op_q == SWM_OP_ROM && bit_q < 7'd8);

    always_comb begin
        state_d = state_q;
        op_d = op_q;
        cnt_d = cnt_q;
        bit_d = bit_q;
        nbits_d = nbits_q;
        sh_d = sh_q;
        bitval_d = bitval_q;
        done_d = 1'b0;
        rd_d = rd_q;
        rom_d = rom_q;
        pres_d = pres_q;
        err_d = err_q;
        seen_d = seen_q;
        crc_bus.clear = 1'b0;
        crc_bus.shift = 1'b0;
        crc_bus.bit_in = bitval_q;
        case (state_q)
            SWM_IDLE: begin
                if (i_cmd_valid) begin
                    op_d = i_cmd_op;
                    cnt_d = '0;
                    bit_d = '0;
                    if (i_cmd_op == SWM_OP_RESET || i_cmd_op == SWM_OP_ROM) begin
                        state_d = SWM_RST_LOW;
                        seen_d = 1'b0;
                    end else begin
                        state_d = SWM_SLOT_LOW;
                        nbits_d = 7'd8;
                        sh_d = {56'h0, i_cmd_data};
                    end
                    if (i_cmd_op == SWM_OP_ROM) begin
                        crc_bus.clear = 1'b1;
                        sh_d = {56'h0, READ_ROM_CMD};
                        nbits_d = 7'(8 + ROM_BITS);
                    end
                    if (i_cmd_op == SWM_OP_READ) begin
                        sh_d = '0;
                    end
                end
            end
            SWM_RST_LOW: begin
                // The low ends at 480 us, well inside the 960 us ceiling.
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == cyc(RESET_LOW_CYC)) begin
                    state_d = SWM_RST_HIGH;
                    cnt_d = '0;
                end
            end
            SWM_RST_HIGH: begin
                cnt_d = cnt_q + 1'b1;
                // Sample after the latest presence start, before it can end.
                if (cnt_q == cyc(PRESENCE_SAMPLE_CYC)) begin
                    seen_d = !line_sync_q;
                end
                if (cnt_q == cyc(RESET_HIGH_CYC)) begin
                    cnt_d = '0;
                    pres_d = seen_q;
                    if (op_q == SWM_OP_ROM && seen_q) begin
                        state_d = SWM_SLOT_LOW;
                    end else begin
                        state_d = SWM_IDLE;
                        done_d = 1'b1;
                    end
                end
            end
            SWM_SLOT_LOW: begin
                // Every slot opens with our fall, which times the slave.
                cnt_d = cnt_q + 1'b1;
                if (reading && cnt_q == cyc(READ_LOW_CYC)) begin
                    state_d = SWM_SLOT_REST;
                end else if (!reading && sh_q[0]
                             && cnt_q == cyc(ONE_LOW_CYC)) begin
                    state_d = SWM_SLOT_REST;
                end else if (!reading && !sh_q[0]
                             && cnt_q == cyc(ZERO_LOW_CYC)) begin
                    state_d = SWM_SLOT_REST;
                end
            end
            SWM_SLOT_REST: begin
                cnt_d = cnt_q + 1'b1;
                if (reading && cnt_q == cyc(READ_SAMPLE_CYC)) begin
                    bitval_d = line_sync_q;
                end
                if (cnt_q == cyc(SLOT_CYC)) begin
                    state_d = SWM_RECOVER;
                    cnt_d = '0;
                end
            end
            SWM_RECOVER: begin
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == cyc(RECOVERY_CYC)) begin
                    cnt_d = '0;
                    bit_d = bit_q + 1'b1;
                    // Bits go out and come in least significant first.
                    sh_d = {(reading ? bitval_q : 1'b0), sh_q[63:1]};
                    if (op_q == SWM_OP_ROM && reading) begin
                        if (bit_q < 7'(8 + DATA_BITS)) begin
                            crc_bus.shift = 1'b1;
                        end
                    end
                    if (bit_q + 1'b1 == nbits_q) begin
                        state_d = SWM_IDLE;
                        done_d = 1'b1;
                        if (op_q == SWM_OP_READ) begin
                            rd_d = {bitval_q, sh_q[63:57]};
                        end
                        if (op_q == SWM_OP_ROM) begin
                            rom_d = {bitval_q, sh_q[63:1]};
                            err_d = ({bitval_q, sh_q[63:57]}
                                     != crc_bus.value);
                        end
                    end else begin
                        state_d = SWM_SLOT_LOW;
                    end
                end
            end
            default: begin
                state_d = SWM_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_q <= SWM_IDLE;
            op_q <= SWM_OP_RESET;
            cnt_q <= '0;
            bit_q <= '0;
            nbits_q <= '0;
            sh_q <= '0;
            bitval_q <= 1'b1;
            done_q <= 1'b0;
            rd_q <= '0;
            rom_q <= '0;
            pres_q <= 1'b0;
            err_q <= 1'b0;
            seen_q <= 1'b0;
        end else begin
            state_q <= state_d;
            op_q <= op_d;
            cnt_q <= cnt_d;
            bit_q <= bit_d;
            nbits_q <= nbits_d;
            sh_q <= sh_d;
            bitval_q <= bitval_d;
            done_q <= done_d;
            rd_q <= rd_d;
            rom_q <= rom_d;
            pres_q <= pres_d;
            err_q <= err_d;
            seen_q <= seen_d;
        end
    end

    // Open drain: we only ever pull low, never drive high.
    assign o_line = 1'b0;
    assign o_line_oe = (state_q == SWM_RST_LOW) || (state_q == SWM_SLOT_LOW);
    assign o_cmd_ready = (state_q == SWM_IDLE);
    assign o_done = done_q;
    assign o_rd_data = rd_q;
    assign o_rom = rom_q;
    assign o_presence = pres_q;
    assign o_crc_err = err_q;
endmodule : swm_master

// ===== swm_slave_model.sv
`timescale 1ns/1ps
module swm_slave_model (
    // Line and setup
    input wire logic i_line,
    input wire logic i_present,
    input wire logic [63:0] i_rom,
    output logic o_pull
);
    logic [7:0] cmd = 8'h00;
    int nbit = 0;
    logic reading = 1'b0;
    realtime t_fall = 0.0;
    initial o_pull = 1'b0;
    // Edges made by the model itself are not slot starts.
    always @(negedge i_line) begin
        if (!o_pull) begin
            t_fall = $realtime;
            if (reading) begin
                if (nbit < 64 && !i_rom[nbit]) begin
                    #100 o_pull = 1'b1;
                    #29900 o_pull = 1'b0;
                end
                nbit = nbit + 1;
            end else begin
                #30000;
                cmd = {i_line, cmd[7:1]};
                nbit = nbit + 1;
                if (nbit == 8) begin
                    reading = (cmd == 8'h33);
                    nbit = 0;
                end
            end
        end
    end
    always @(posedge i_line) begin
        if (!o_pull && $realtime - t_fall >= 480000.0) begin
            reading = 1'b0;
            nbit = 0;
            #30000 o_pull = i_present;
            #120000 o_pull = 1'b0;
            t_fall = $realtime;
        end
    end
endmodule : swm_slave_model

// ===== swm_master_assertions.sv
`timescale 1ns/1ps
module swm_master_assertions
    import swm_pkg::*;
(
    // Watched ports
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic o_done,
    input wire logic o_crc_err,
    input wire logic o_line_oe
);
    localparam int RST_MAX = RESET_LOW_MAX_US * CLK_MHZ;
    localparam int US = CLK_MHZ;
    logic oe_q, rst_q, oe_d, rst_d;
    logic [16:0] low_q, high_q, last_q, low_d, high_d, last_d;
    always_comb begin
        oe_d = o_line_oe;
        low_d = o_line_oe ? low_q + 17'h1 : 17'h0;
        high_d = (o_line_oe) ? 17'h0 : high_q + {16'h0, ~&high_q};
        last_d = (oe_q && !o_line_oe) ? low_q : last_q;
        rst_d = (oe_q && !o_line_oe) ? (low_q >= 17'(RESET_LOW_CYC)) :
            (o_line_oe ? 1'b0 : rst_q);
    end
    // Both counters start saturated: the line idles high through reset, and
    // the first slot has no earlier low to be judged against.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            oe_q <= 1'b0;
            rst_q <= 1'b0;
            low_q <= 17'h0;
            high_q <= 17'h1ffff;
            last_q <= 17'h1ffff;
        end else begin
            oe_q <= oe_d;
            rst_q <= rst_d;
            low_q <= low_d;
            high_q <= high_d;
            last_q <= last_d;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    a_reset_low_cap: assert property (
        o_line_oe |-> low_q < RST_MAX) else $error("reset low too long");
    a_reset_low_min: assert property (
        $fell(o_line_oe) && low_q >= 120 * US |-> low_q >= RESET_LOW_CYC)
        else $error("reset low too short");
    a_short_low_len: assert property (
        $fell(o_line_oe) && low_q < 15 * US |-> low_q >= US)
        else $error("short low under one microsecond");
    a_zero_low_len: assert property (
        $fell(o_line_oe) && low_q >= 15 * US && low_q < 120 * US
        |-> low_q >= 60 * US) else $error("zero low out of range");
    a_recovery_min: assert property (
        $rose(o_line_oe) |-> high_q >= US) else $error("recovery too short");
    a_reset_high_wait: assert property (
        $rose(o_line_oe) && rst_q |-> high_q >= RESET_HIGH_CYC)
        else $error("reset high interval too short");
    a_slot_min_len: assert property (
        $rose(o_line_oe) && !rst_q |-> int'(last_q) + int'(high_q) >= 60 * US)
        else $error("slot too short");
    a_crc_err_hold: assert property (
        $changed(o_crc_err) |-> o_done || $past(o_done))
        else $error("crc flag moved outside completion");
endmodule : swm_master_assertions
bind swm_master swm_master_assertions u_chk (.i_clk(i_clk),
    .i_arst_n(i_arst_n), .o_done(o_done), .o_crc_err(o_crc_err),
    .o_line_oe(o_line_oe));

// ===== swm_master_tb.sv
`timescale 1ns/1ps
module swm_master_tb;
    import swm_pkg::*;
    // Arbitrary family value for the model.
    localparam logic [7:0] FAMILY = 8'h5a;
    logic i_clk, i_arst_n, i_cmd_valid, i_line, o_line, o_line_oe, pull;
    logic o_cmd_ready, o_done, o_presence, o_crc_err, present;
    swm_op_t i_cmd_op;
    logic [7:0] i_cmd_data, o_rd_data;
    logic [7:0] wr_byte;
    logic [63:0] o_rom, rom;
    logic [31:0] r;
    int unsigned seed;
    int failures = 0;
    int check_count = 0;
    assign i_line = (o_line_oe ? o_line : 1'b1) & ~pull;
    swm_master dut (.i_clk(i_clk), .i_arst_n(i_arst_n),
        .i_cmd_valid(i_cmd_valid), .i_cmd_op(i_cmd_op),
        .i_cmd_data(i_cmd_data), .o_cmd_ready(o_cmd_ready), .o_done(o_done),
        .o_rd_data(o_rd_data), .o_rom(o_rom), .o_presence(o_presence),
        .o_crc_err(o_crc_err), .i_line(i_line), .o_line(o_line),
        .o_line_oe(o_line_oe));
    swm_slave_model slave (.i_line(i_line), .i_present(present),
        .i_rom(rom), .o_pull(pull));
    function automatic logic [7:0] crc_of(input logic [55:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < 56; i++) begin
            c = (c >> 1) ^ ((c[0] ^ d[i]) ? 8'h8c : 8'h00);
        end
        return c;
    endfunction : crc_of
    task automatic check(input string name, input logic [63:0] seen,
                         input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic run_cmd(input swm_op_t op, input logic [7:0] d);
        int n;
        n = 0;
        @(negedge i_clk);
        i_cmd_valid = 1'b1;
        i_cmd_op = op;
        i_cmd_data = d;
        @(posedge i_clk);
        @(negedge i_clk);
        i_cmd_valid = 1'b0;
        while (o_done !== 1'b1 && n < 260000) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        if (o_done !== 1'b1) begin
            failures++;
            print_verdict();
        end
    endtask : run_cmd
    task automatic print_verdict;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : print_verdict
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    // A full ROM read takes about 249k cycles; with the shorter commands the
    // run needs about 396k, and the limit leaves a margin.
    initial begin
        repeat (450000) @(posedge i_clk);
        failures++;
        print_verdict();
    end
    initial begin
        i_arst_n = 1'b0;
        i_cmd_valid = 1'b0;
        i_cmd_op = SWM_OP_RESET;
        i_cmd_data = 8'h00;
        present = 1'b1;
        rom = 64'h0;
        seed = $urandom(32'h1e12);
        repeat (20) @(negedge i_clk);
        i_arst_n = 1'b1;
        check("ready", o_cmd_ready, 64'h1);
        check("line_oe", o_line_oe, 64'h0);
        check("line", o_line, 64'h0);
        r = $urandom;
        rom[39:8] = r;
        r = $urandom;
        rom[55:40] = r[15:0];
        rom[7:0] = FAMILY;
        rom[63:56] = crc_of(rom[55:0]);
        run_cmd(SWM_OP_ROM, r[23:16]);
        check("rom", o_rom, rom);
        check("presence", o_presence, 64'h1);
        check("crc_err", o_crc_err, 64'h0);
        check("command", slave.cmd, 64'(READ_ROM_CMD));
        $display("test rom_read done");
        run_cmd(SWM_OP_RESET, 8'h00);
        check("presence", o_presence, 64'h1);
        check("ready", o_cmd_ready, 64'h1);
        $display("test reset done");
        // The model only listens after a reset, and would answer 33h.
        r = $urandom;
        wr_byte = (r[7:0] == READ_ROM_CMD) ? ~r[7:0] : r[7:0];
        run_cmd(SWM_OP_WRITE, wr_byte);
        check("write", slave.cmd, 64'(wr_byte));
        run_cmd(SWM_OP_WRITE, READ_ROM_CMD);
        check("write_cmd", slave.cmd, 64'(READ_ROM_CMD));
        run_cmd(SWM_OP_READ, 8'h00);
        check("read", o_rd_data, 64'(rom[7:0]));
        $display("test byte_io done");
        present = 1'b0;
        run_cmd(SWM_OP_ROM, r[31:24]);
        check("presence", o_presence, 64'h0);
        check("line_oe", o_line_oe, 64'h0);
        $display("test no_presence done");
        print_verdict();
    end
endmodule : swm_master_tb
